/* File: verilog/ams_params.svh */
// Constants of the analog input multiplexer sequencer: register offsets,
// field positions, engine memory words and clock figures.
// Assumes it is included by bare name from every file that needs it.
//
// Operation
// - Four sources: current one, voltage, current two, temperature.
// - Normal cycle selects only the three external inputs.
// - Alternate cycle swaps temperature for first current.
// - Equation code sets alternate third state usage.
// - Five control fields in three mapped bytes drive the sequencer.
// - States per cycle selectable as two, three, four, six.
// - One-cycle request pulse is still registered.
// - Request rising edge gives one alternate cycle next.
// - Sequencer starts filter and drives reference chopping.
// - Runs on slow clock; starts every engine pass.
// - Engine interpolates first current samples lost.
// - Conversion lasts two or three slow clock ticks.
// - Engine pass starts when multiplexer state zero begins.
// - Filter result stored at source's engine memory word.
// - Chop control: regular, inverted, or toggling per cycle.
`ifndef AMS_PARAMS_SVH
`define AMS_PARAMS_SVH

// Byte addresses of the control bytes
`define AMS_ADDR_EQUATION   16'h2000
`define AMS_ADDR_DIVIDER    16'h2002
`define AMS_ADDR_ALTERNATE  16'h2005

// Field positions inside the control bytes
`define AMS_EQU_MSB         7
`define AMS_EQU_LSB         5
`define AMS_DIV_MSB         7
`define AMS_DIV_LSB         6
`define AMS_CHOP_MSB        5
`define AMS_CHOP_LSB        4
`define AMS_ALT_BIT         2
`define AMS_FIRLEN_BIT      4

// Reset values of the fields
`define AMS_EQU_RESET       3'h0
`define AMS_DIV_RESET       2'h1
`define AMS_CHOP_RESET      2'h0

// Equation code that keeps the second current in the alternate cycle
`define AMS_EQU_THREE_WIRE  3'h1

// Conversion length in slow clock ticks
`define AMS_CONV_SHORT      2'h2
`define AMS_CONV_LONG       2'h3

// Engine data memory words per source
`define AMS_DRAM_I1         3'h0
`define AMS_DRAM_V          3'h1
`define AMS_DRAM_I2         3'h2
`define AMS_DRAM_TEMP       3'h6

// Clock figures, for reference of the cycle arithmetic
`define AMS_SYS_CLK_HZ      250000000
`define AMS_SLOW_CLK_HZ     32768

// Widths and buffer depth
`define AMS_FILT_W          22
`define AMS_DADDR_W         3
`define AMS_FIFO_DEPTH      8

`endif

/* File: verilog/ams_pkg.sv */
// Types of the analog input multiplexer sequencer.
// Assumes ams_params.svh is available on the include path.
package ams_pkg;

    // Multiplexer source codes
    typedef enum logic [1:0]
    {
        AMS_SRC_I1   = 2'b00,
        AMS_SRC_V    = 2'b01,
        AMS_SRC_I2   = 2'b10,
        AMS_SRC_TEMP = 2'b11
    } ams_src_t;

    // Sequencer states
    typedef enum logic [1:0]
    {
        AMS_ST_WAIT = 2'b00,
        AMS_ST_CONV = 2'b01,
        AMS_ST_GAP  = 2'b10
    } ams_state_t;

    // Reference chop modes
    typedef enum logic [1:0]
    {
        AMS_CHOP_REGULAR  = 2'b00,
        AMS_CHOP_INVERTED = 2'b01,
        AMS_CHOP_TOGGLE   = 2'b10,
        AMS_CHOP_TOGGLE2  = 2'b11
    } ams_chop_t;

endpackage

/* File: verilog/ams_fifo.sv */
// Small FIFO with valid/ready on both sides and a registered output.
// Assumes DEPTH is a power of two and one synchronous clock domain.
`timescale 1ns/1ps
module ams_fifo
    import ams_pkg::*;
#(
    parameter int WIDTH = 25,
    parameter int DEPTH = 8
)
(
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push;
    wire              load;
    wire              pop;

    // Output register refills whenever it is empty or being taken
    assign o_in_ready = (count != (AW+1)'(DEPTH));
    assign push       = i_in_valid & o_in_ready;
    assign load       = ~o_out_valid | i_out_ready;
    assign pop        = load & (count != '0);

    // Storage has no reset; pointers, count and output stage are reset
    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wr_ptr] <= i_in_data;
    end

    // Pointers, fill level and output stage
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            o_out_valid <= 1'b0;
            o_out_data  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + AW'(1);
            if (pop)
            begin
                rd_ptr     <= rd_ptr + AW'(1);
                o_out_data <= mem[rd_ptr];
            end
            if (load)
                o_out_valid <= pop;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* File: verilog/ams_sequencer.sv */
// Multiplexer sequencer of the analog front end: control bytes, slow
// clock stepping, alternate temperature cycle, reference chopping, filter
// and engine start, and buffered storage of filter results.
// Assumes a byte-wide memory-mapped control port on the system clock, the
// slow clock arriving as a free-running pin, and a filter result that is
// valid at every conversion end.
`timescale 1ns/1ps
`include "ams_params.svh"
module ams_sequencer
    import ams_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_slow_clock_32k,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    input  wire logic [21:0] i_filter_data,
    output logic      [1:0]  o_mux_select,
    output logic             o_mux_used,
    output logic             o_conv_start,
    output logic             o_filter_length_select,
    output logic             o_ref_chop,
    output logic             o_ce_start,
    output logic             o_alt_active,
    output logic             o_dram_valid,
    input  wire logic        i_dram_ready,
    output logic      [2:0]  o_dram_addr,
    output logic      [21:0] o_dram_data
);
    localparam int DW = `AMS_DADDR_W + `AMS_FILT_W;

    // ****************************************************************
    // Functions
    // ****************************************************************

    // States per cycle from the divider field
    function automatic logic [2:0] states_of(input logic [1:0] div);
        logic [2:0] n;
        n = 3'h4;
        unique case (div)
            2'b00: n = 3'h6;
            2'b01: n = 3'h4;
            2'b10: n = 3'h3;
            2'b11: n = 3'h2;
        endcase
        return n;
    endfunction

    // Engine memory word of a source
    function automatic logic [2:0] dram_of(input ams_src_t src);
        logic [2:0] a;
        a = `AMS_DRAM_I1;
        unique case (src)
            AMS_SRC_I1:   a = `AMS_DRAM_I1;
            AMS_SRC_V:    a = `AMS_DRAM_V;
            AMS_SRC_I2:   a = `AMS_DRAM_I2;
            AMS_SRC_TEMP: a = `AMS_DRAM_TEMP;
        endcase
        return a;
    endfunction

    // ****************************************************************
    // Control bytes
    // ****************************************************************

    logic [2:0] equation;
    logic [1:0] divider;
    logic [1:0] chop_ctrl;
    logic       alt_request;
    logic       filter_len;
    wire        wr_equ;
    wire        wr_div;
    wire        wr_alt;

    assign wr_equ = i_reg_wr & (i_reg_addr == `AMS_ADDR_EQUATION);
    assign wr_div = i_reg_wr & (i_reg_addr == `AMS_ADDR_DIVIDER);
    assign wr_alt = i_reg_wr & (i_reg_addr == `AMS_ADDR_ALTERNATE);

    // Field stores; other bits of the bytes are not kept
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            equation    <= `AMS_EQU_RESET;
            divider     <= `AMS_DIV_RESET;
            chop_ctrl   <= `AMS_CHOP_RESET;
            alt_request <= 1'b0;
            filter_len  <= 1'b0;
        end
        else
        begin
            if (wr_equ)
                equation <= i_reg_wdata[`AMS_EQU_MSB:`AMS_EQU_LSB];
            if (wr_div)
            begin
                divider   <= i_reg_wdata[`AMS_DIV_MSB:`AMS_DIV_LSB];
                chop_ctrl <= i_reg_wdata[`AMS_CHOP_MSB:`AMS_CHOP_LSB];
            end
            if (wr_alt)
            begin
                alt_request <= i_reg_wdata[`AMS_ALT_BIT];
                filter_len  <= i_reg_wdata[`AMS_FIRLEN_BIT];
            end
        end
    end

    // Read mux; unmapped addresses and reserved bits read zero
    logic [7:0] next_rdata;
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (i_reg_addr)
            `AMS_ADDR_EQUATION:
                next_rdata[`AMS_EQU_MSB:`AMS_EQU_LSB] = equation;
            `AMS_ADDR_DIVIDER:
            begin
                next_rdata[`AMS_DIV_MSB:`AMS_DIV_LSB]   = divider;
                next_rdata[`AMS_CHOP_MSB:`AMS_CHOP_LSB] = chop_ctrl;
            end
            `AMS_ADDR_ALTERNATE:
            begin
                next_rdata[`AMS_ALT_BIT]    = alt_request;
                next_rdata[`AMS_FIRLEN_BIT] = filter_len;
            end
            default:
                next_rdata = 8'h00;
        endcase
    end

    // ****************************************************************
    // Slow clock synchroniser and alternate request capture
    // ****************************************************************

    logic sync_a;
    logic sync_b;
    logic slow_q;
    logic alt_q;
    logic alt_pending;
    wire  slow_rise;
    wire  alt_rise;

    // Only sync_b reads sync_a; edge logic looks at sync_b and slow_q
    assign slow_rise = sync_b & ~slow_q;
    assign alt_rise  = alt_request & ~alt_q;

    // ****************************************************************
    // Sequencer
    // ****************************************************************

    ams_state_t state;
    ams_state_t next_state;
    logic [2:0] slot;
    logic [1:0] phase;
    logic [2:0] cyc_states;
    logic [1:0] cyc_conv;
    logic [2:0] cyc_equ;
    logic       alt_cycle;
    logic       chop_phase;
    ams_src_t   src;
    logic       src_used;
    logic       fifo_in_ready;
    wire        advance;
    wire        boundary;
    wire        conv_end;
    wire        last_slot;
    wire        push;
    wire [DW-1:0] push_data;

    // A full buffer freezes stepping so no result is ever dropped
    assign advance   = slow_rise & fifo_in_ready;
    assign boundary  = advance & (state != AMS_ST_CONV);
    assign conv_end  = advance & (state == AMS_ST_CONV)
                     & (phase == cyc_conv - 2'h1);
    assign last_slot = (slot == cyc_states - 3'h1);
    assign push      = conv_end & src_used;
    assign push_data = {dram_of(src), i_filter_data};

    // Source per slot; temperature only in the alternate cycle
    always_comb
    begin
        src      = AMS_SRC_I1;
        src_used = 1'b0;
        unique case (slot)
            3'h0:
            begin
                src      = alt_cycle ? AMS_SRC_TEMP : AMS_SRC_I1;
                src_used = 1'b1;
            end
            3'h1:
            begin
                src      = AMS_SRC_V;
                src_used = 1'b1;
            end
            3'h2:
            begin
                src      = AMS_SRC_I2;
                src_used = ~alt_cycle
                         | (cyc_equ == `AMS_EQU_THREE_WIRE);
            end
            default:
            begin
                src      = AMS_SRC_I1;
                src_used = 1'b0;
            end
        endcase
    end

    // Next state of the stepping machine
    always_comb
    begin
        next_state = state;
        unique case (state)
            AMS_ST_WAIT: if (advance) next_state = AMS_ST_CONV;
            AMS_ST_CONV: if (conv_end && last_slot) next_state = AMS_ST_GAP;
            AMS_ST_GAP:  if (advance) next_state = AMS_ST_CONV;
            default:     next_state = AMS_ST_WAIT;
        endcase
    end

    // Synchroniser, request edge and pending flag
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            sync_a      <= 1'b0;
            sync_b      <= 1'b0;
            slow_q      <= 1'b0;
            alt_q       <= 1'b0;
            alt_pending <= 1'b0;
        end
        else
        begin
            sync_a <= i_slow_clock_32k;
            sync_b <= sync_a;
            slow_q <= sync_b;
            alt_q  <= alt_request;
            // A new edge in the consuming cycle wins over the clear
            if (alt_rise)
                alt_pending <= 1'b1;
            else if (boundary)
                alt_pending <= 1'b0;
        end
    end

    // Cycle boundary latches settings so a cycle is never reshaped midway
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state      <= AMS_ST_WAIT;
            slot       <= 3'h0;
            phase      <= 2'h0;
            cyc_states <= 3'h4;
            cyc_conv   <= `AMS_CONV_SHORT;
            cyc_equ    <= `AMS_EQU_RESET;
            alt_cycle  <= 1'b0;
            chop_phase <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (boundary)
            begin
                slot       <= 3'h0;
                phase      <= 2'h0;
                cyc_states <= states_of(divider);
                cyc_conv   <= filter_len ? `AMS_CONV_LONG
                                         : `AMS_CONV_SHORT;
                cyc_equ    <= equation;
                alt_cycle  <= alt_pending;
                chop_phase <= ~chop_phase;
            end
            else if (conv_end)
            begin
                phase <= 2'h0;
                slot  <= slot + 3'h1;
            end
            else if (advance)
                phase <= phase + 2'h1;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    logic       next_chop;
    logic [1:0] start_q;
    wire        next_conv_start;

    // Conversion and engine starts lag a clock to meet the select
    assign next_conv_start = boundary | (conv_end & ~last_slot);

    // Chop polarity from the mode; toggle follows the cycle parity
    always_comb
    begin
        next_chop = 1'b0;
        unique case (ams_chop_t'(chop_ctrl))
            AMS_CHOP_REGULAR:  next_chop = 1'b0;
            AMS_CHOP_INVERTED: next_chop = 1'b1;
            AMS_CHOP_TOGGLE:   next_chop = chop_phase;
            AMS_CHOP_TOGGLE2:  next_chop = chop_phase;
        endcase
    end

    // Registered outputs
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_reg_rdata            <= 8'h00;
            o_mux_select           <= 2'h0;
            o_mux_used             <= 1'b0;
            o_conv_start           <= 1'b0;
            start_q                <= 2'h0;
            o_filter_length_select <= 1'b0;
            o_ref_chop             <= 1'b0;
            o_ce_start             <= 1'b0;
            o_alt_active           <= 1'b0;
        end
        else
        begin
            o_reg_rdata            <= next_rdata;
            o_mux_select           <= src;
            o_mux_used             <= src_used & (state == AMS_ST_CONV);
            start_q                <= {boundary, next_conv_start};
            o_conv_start           <= start_q[0];
            o_filter_length_select <= cyc_conv == `AMS_CONV_LONG;
            o_ref_chop             <= next_chop;
            o_ce_start             <= start_q[1];
            // Tells the engine which first current samples to fill in
            o_alt_active           <= alt_cycle;
        end
    end

    // ****************************************************************
    // Result buffer toward engine data memory
    // ****************************************************************

    logic [DW-1:0] dram_word;

    assign o_dram_addr = dram_word[DW-1:`AMS_FILT_W];
    assign o_dram_data = dram_word[`AMS_FILT_W-1:0];

    ams_fifo #(
        .WIDTH (DW),
        .DEPTH (`AMS_FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_in_valid  (push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (push_data),
        .o_out_valid (o_dram_valid),
        .i_out_ready (i_dram_ready),
        .o_out_data  (dram_word)
    );
endmodule

/* File: bench/ams_sequencer_sva.sv */
// Checker of the sequencer's top ports, bound into every instance.
// Assumes one clock domain and the registered outputs of the hand-over.
`timescale 1ns/1ps
module ams_sequencer_sva
    import ams_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic [15:0] i_reg_addr,
    input wire logic        i_dram_ready,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic [1:0]  o_mux_select,
    input wire logic        o_mux_used,
    input wire logic        o_conv_start,
    input wire logic        o_filter_length_select,
    input wire logic        o_ce_start,
    input wire logic        o_alt_active,
    input wire logic        o_dram_valid,
    input wire logic [2:0]  o_dram_addr,
    input wire logic [21:0] o_dram_data
);
    // ****************************************
    // Properties
    // ****************************************
    // Every check pauses while reset is held
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    AST_TEMP_ONLY_ALT: assert property (
        o_mux_used && o_mux_select == AMS_SRC_TEMP |-> o_alt_active)
        else $error("temperature sampled in a normal cycle");
    AST_ALT_NO_I1: assert property (
        o_alt_active && o_mux_used |-> o_mux_select != AMS_SRC_I1)
        else $error("first current sampled in an alternate cycle");
    AST_CE_STATE0: assert property (
        o_ce_start |-> o_conv_start && o_mux_select ==
        (o_alt_active ? AMS_SRC_TEMP : AMS_SRC_I1))
        else $error("engine start not at state zero");
    AST_CE_ONE: assert property (
        o_ce_start |=> !o_ce_start)
        else $error("engine start longer than one clock");
    AST_CONV_ONE: assert property (
        o_conv_start |=> !o_conv_start [*2])
        else $error("conversion starts too close");
    AST_ALT_ROSE: assert property (
        $rose(o_alt_active) |-> o_ce_start)
        else $error("alternate cycle began off a boundary");
    AST_ALT_FELL: assert property (
        $fell(o_alt_active) |-> o_ce_start)
        else $error("alternate cycle ended off a boundary");
    AST_FLEN_LATCH: assert property (
        $changed(o_filter_length_select) |-> ##[0:1] o_ce_start)
        else $error("filter length changed inside a cycle");
    AST_DRAM_HOLD: assert property (
        o_dram_valid && !i_dram_ready |=> o_dram_valid
        && $stable(o_dram_addr) && $stable(o_dram_data))
        else $error("result word dropped while stalled");
    AST_DRAM_WORD: assert property (
        o_dram_valid |-> o_dram_addr inside {3'h0, 3'h1, 3'h2, 3'h6})
        else $error("result word at a reserved address");
    AST_RD_UNMAPPED: assert property (
        !(i_reg_addr inside {16'h2000, 16'h2002, 16'h2005})
        |=> o_reg_rdata == 8'h00)
        else $error("unmapped byte read nonzero");
    AST_RD_RESERVED: assert property (
        i_reg_addr == 16'h2005 |=> (o_reg_rdata & 8'hEB) == 8'h00)
        else $error("reserved bits read nonzero");
endmodule

bind ams_sequencer ams_sequencer_sva u_sva
(
    .i_clk, .i_resetn, .i_reg_addr, .i_dram_ready, .o_reg_rdata,
    .o_mux_select, .o_mux_used, .o_conv_start, .o_filter_length_select,
    .o_ce_start, .o_alt_active, .o_dram_valid, .o_dram_addr, .o_dram_data
);

/* File: bench/ams_engine_model.sv */
// Model of the engine data memory and of the filter feeding the block.
// Assumes the bench reads its log of stored words by hierarchy.
`timescale 1ns/1ps
module ams_engine_model
    import ams_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_stall,
    input  wire logic        i_dram_valid,
    input  wire logic [2:0]  i_dram_addr,
    output logic             o_dram_ready,
    output logic      [21:0] o_filter_data
);
    logic [2:0] seen [0:1023];
    int         n_seen;

    // ****************************************
    // Memory port
    // ****************************************
    // Ready trails the stall request by a clock, as a busy port would
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_dram_ready  <= 1'b0;
            o_filter_data <= 22'h0;
            n_seen        <= 0;
        end
        else
        begin
            o_dram_ready  <= !i_stall;
            o_filter_data <= o_filter_data + 22'h2AB5; // Never holds still
            if (i_dram_valid && o_dram_ready)
            begin
                seen[n_seen[9:0]] <= i_dram_addr;
                n_seen            <= n_seen + 1;
            end
        end
    end
endmodule

/* File: bench/tb.sv */
// Testbench of the sequencer: control bytes, cycle lengths, alternate
// cycles, chopping and result back-pressure.
// Assumes the engine model and the bound checker are compiled with it.
`timescale 1ns/1ps
`include "ams_params.svh"
module tb
    import ams_pkg::*;
;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic        slow = 1'b0;
    logic        wr = 1'b0;
    logic        stall = 1'b0;
    logic        ready;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  r;
    logic [21:0] filt;
    logic [7:0]  o_reg_rdata;
    logic [1:0]  o_mux_select;
    logic        o_mux_used, o_conv_start, o_filter_length_select;
    logic        o_ref_chop, o_ce_start, o_alt_active, o_dram_valid;
    logic [2:0]  o_dram_addr;
    logic [21:0] o_dram_data;
    int          err_total = 0;
    int          comparisons = 0;
    int          seed, n0, ce_n;

    ams_sequencer DUT
    (
        .i_clk, .i_resetn, .i_slow_clock_32k(slow), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata,
        .i_filter_data(filt), .o_mux_select, .o_mux_used, .o_conv_start,
        .o_filter_length_select, .o_ref_chop, .o_ce_start, .o_alt_active,
        .o_dram_valid, .i_dram_ready(ready), .o_dram_addr, .o_dram_data
    );

    ams_engine_model u_eng
    (
        .i_clk, .i_resetn, .i_stall(stall), .i_dram_valid(o_dram_valid),
        .i_dram_addr(o_dram_addr), .o_dram_ready(ready), .o_filter_data(filt)
    );

    // ****************************************
    // Clocks, tasks and expectations
    // ****************************************
    // Slow clock far above 32768 Hz to fit the run: 20 clocks a period
    always #2 i_clk = ~i_clk;
    always #40 slow = ~slow;

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic wreg(logic [15:0] a, logic [7:0] d);
        @(posedge i_clk) #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge i_clk) #1 wr = 1'b0;
    endtask

    task automatic rreg(logic [15:0] a, logic [7:0] exp);
        @(posedge i_clk) #1 addr = a;
        @(posedge i_clk) #1 chk("reg_read", exp, o_reg_rdata);
    endtask

    // Bounded wait; returns just after the edge that raises the engine start pulse
    task automatic wait_ce();
        int n;
        n = 0;
        do
        begin
            @(posedge i_clk) #1 n++;
        end
        while (o_ce_start !== 1'b1 && n < 2000);
        if (o_ce_start !== 1'b1) chk("ce_start", 1, 0);
    endtask

    function automatic int n_states(int d);
        return (d == 0) ? 6 : 5 - d;
    endfunction

    // Slot to {stored, word}: I1 0, V 1, I2 2, temperature 6
    function automatic logic [3:0] slot_word(int s, logic alt,
                                             logic [2:0] meter_equation_field);
        case (s)
            0: return alt ? 4'hE : 4'h8;
            1: return 4'h9;
            2: return {!alt || meter_equation_field == 3'h1, 3'h2};
            default: return 4'h0;
        endcase
    endfunction

    // Called at a boundary: checks length and stored words of one cycle
    task automatic cyc(int nst, int conv, logic alt, logic [2:0] meter_equation_field);
        time        t0;
        int         k;
        logic [3:0] w;
        t0 = $time;
        k = u_eng.n_seen;
        chk("alt_active", alt, o_alt_active);
        wait_ce();
        chk("cycle_clks", (nst * conv + 1) * 20, 32'(($time - t0) / 4));
        for (int s = 0; s < nst; s++)
        begin
            w = slot_word(s, alt, meter_equation_field);
            if (w[3])
            begin
                chk("dram_addr", w[2:0], u_eng.seen[k[9:0]]);
                k++;
            end
        end
        chk("word_count", k, u_eng.n_seen);
    endtask

    task automatic stop_test();
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog: the sequence needs some 10000 clocks
    initial
    begin
        repeat (80000) @(posedge i_clk);
        err_total++;
        stop_test();
    end

    // Main sequence
    initial
    begin
        seed = $urandom(32'h372A);
        repeat (4) @(posedge i_clk);
        #1 i_resetn = 1'b1;
        rreg(`AMS_ADDR_EQUATION, 8'h00);
        rreg(`AMS_ADDR_DIVIDER, 8'h40);
        rreg(`AMS_ADDR_ALTERNATE, 8'h00);
        repeat (8)
        begin
            r = 8'($urandom);
            wreg(`AMS_ADDR_EQUATION, r);
            rreg(`AMS_ADDR_EQUATION, r & 8'hE0);
            wreg(`AMS_ADDR_DIVIDER, r);
            rreg(`AMS_ADDR_DIVIDER, r & 8'hF0);
            wreg(16'h2006 + 16'(r), r);
            rreg(16'h2006 + 16'(r), 8'h00);
        end
        // Every divider code with both conversion lengths
        wreg(`AMS_ADDR_EQUATION, 8'h00);
        for (int d = 0; d < 4; d++)
            for (int f = 0; f < 2; f++)
            begin
                wreg(`AMS_ADDR_DIVIDER, {d[1:0], 6'h00});
                wreg(`AMS_ADDR_ALTERNATE, {3'h0, f[0], 4'h0});
                rreg(`AMS_ADDR_ALTERNATE, {3'h0, f[0], 4'h0});
                wait_ce();
                wait_ce();
                chk("filter_length", f, o_filter_length_select);
                cyc(n_states(d), 2 + f, 1'b0, 3'h0);
            end
        // Rare one-clock requests; a second one merges into the first
        wreg(`AMS_ADDR_DIVIDER, 8'h40);
        wreg(`AMS_ADDR_ALTERNATE, 8'h00);
        for (int e = 0; e < 2; e++)
        begin
            wreg(`AMS_ADDR_EQUATION, {e[2:0], 5'h00});
            wait_ce();
            wait_ce();
            repeat (e + 1)
            begin
                @(posedge i_clk) #1 addr = `AMS_ADDR_ALTERNATE;
                wdata = 8'h04;
                wr = 1'b1;
                @(posedge i_clk) #1 wdata = 8'h00;
                @(posedge i_clk) #1 wr = 1'b0;
            end
            chk("alt_early", 0, o_alt_active);
            wait_ce();
            cyc(4, 2, 1'b1, e[2:0]);
            cyc(4, 2, 1'b0, e[2:0]);
        end
        // Chop modes: fixed levels, then toggling between cycles
        for (int m = 0; m < 4; m++)
        begin
            wreg(`AMS_ADDR_DIVIDER, {2'b01, m[1:0], 4'h0});
            wait_ce();
            wait_ce();
            #12 r[0] = o_ref_chop;
            if (m < 2) chk("chop_level", m, r[0]);
            wait_ce();
            #12 chk("chop_next", r[0] ^ m[1], o_ref_chop);
        end
        // Memory stalls until the buffer fills and stepping stops
        wreg(`AMS_ADDR_DIVIDER, 8'h40);
        @(posedge i_clk) #1 stall = 1'b1;
        #8 n0 = u_eng.n_seen;
        ce_n = 0;
        #4000;
        repeat (500) @(posedge i_clk) #1 ce_n += int'(o_ce_start);
        chk("frozen_words", n0, u_eng.n_seen);
        chk("frozen_starts", 0, ce_n);
        stall = 1'b0;
        #72 chk("drained_words", n0 + 9, u_eng.n_seen);
        wait_ce();
        cyc(4, 2, 1'b0, 3'h0);
        stop_test();
    end
endmodule
